// file: dtpwm_load.sv
////////////////////////////////////////////////////////////////////////////////
// Passive load on the PWM pins: counts the cycles that each pin spends high.
module dtpwm_load (
    // Clock and measurement control.
    input  wire logic        i_clk,
    input  wire logic        i_clear,
    input  wire logic        i_en,
    // Four PWM levels, then the primary and secondary match pulses.
    input  wire logic [5:0]  i_pins,
    // High-cycle count of each pin.
    output logic      [15:0] o_hi [6]
);
    // A load only observes, so counting is its whole behaviour.
    always_ff @(posedge i_clk) begin
        for (int k = 0; k < 6; k++) begin
            if (i_clear) begin
                o_hi[k] <= 16'h0000;
            end else if (i_en) begin
                o_hi[k] <= o_hi[k] + {15'h0000, i_pins[k]};
            end
        end
    end
endmodule : dtpwm_load

// file: dtpwm_timer.sv
////////////////////////////////////////////////////////////////////////////////
// Shared constants for the dual timer PWM output block.
package dtpwm_pkg;

    // Widths.
    localparam int          CNT_W       = 16;
    localparam int          ADDR_W      = 8;
    localparam int          DATA_W      = 32;
    localparam int          NUM_TMR     = 2;
    localparam int          NUM_CMP     = 4;

    // Register byte addresses.
    localparam logic [7:0]  ADDR_CTRL0_T0  = 8'h00;
    localparam logic [7:0]  ADDR_CTRL0_T1  = 8'h04;
    localparam logic [7:0]  ADDR_CTRL1_PRI = 8'h08;
    localparam logic [7:0]  ADDR_STATUS    = 8'h0c;
    localparam logic [7:0]  ADDR_CMP_T0    = 8'h10;
    localparam logic [7:0]  ADDR_CMP_T1    = 8'h20;
    localparam logic [7:0]  ADDR_COUNT     = 8'h30;
    localparam logic [7:0]  CMP_SPAN       = 8'h10;

    // Field positions.
    localparam int          RUN_BIT      = 7;
    localparam int          DUAL_BIT     = 0;
    localparam int          MODE_LSB     = 0;
    localparam int          ST_OUT_LSB   = 0;
    localparam int          ST_PEND_LSB  = 4;
    localparam int          ST_RUN_LSB   = 6;
    localparam int          CMP_IDX_LSB  = 2;

    // Compare register indices.
    localparam logic [1:0]  CMP_IDX_SINGLE = 2'h1;
    localparam logic [1:0]  CMP_IDX_DUAL   = 2'h3;

    // Reset values and window length.
    localparam logic [15:0] CMP_RESET    = 16'h0000;
    localparam logic [15:0] CNT_CLEAR    = 16'h0000;
    localparam logic [1:0]  AGE_COMMIT   = 2'h2;
    localparam logic [1:0]  AGE_MAX      = 2'h3;

    // Operating modes of the pair of timers.
    typedef enum logic [1:0] {
        DTPWM_MODE_INDEP      = 2'b00,
        DTPWM_MODE_SYNC_START = 2'b01,
        DTPWM_MODE_SYNC_CLEAR = 2'b11
    } dtpwm_mode_e;

    // Selects the compare register that closes the cycle and commits updates.
    function automatic logic [1:0] dtpwm_commit_idx(input logic dual);
        dtpwm_commit_idx = dual ? CMP_IDX_DUAL : CMP_IDX_SINGLE;
    endfunction : dtpwm_commit_idx

endpackage : dtpwm_pkg

////////////////////////////////////////////////////////////////////////////////
// One 16-bit counter with its two PWM outputs.
module dtpwm_timer #(
    parameter int W = dtpwm_pkg::CNT_W
) (
    // Clock, reset and enable.
    input  wire logic         i_clk,
    input  wire logic         i_reset,
    input  wire logic         i_ce,
    // Control.
    input  wire logic         i_run,
    input  wire logic         i_dual,
    input  wire logic [W-1:0] i_period,
    input  wire logic [W-1:0] i_cmp0,
    input  wire logic [W-1:0] i_cmp1,
    input  wire logic [W-1:0] i_cmp2,
    input  wire logic [W-1:0] i_cmp3,
    // Status and outputs.
    output logic [W-1:0]      o_count,
    output logic              o_wrap,
    output logic              o_out_first,
    output logic              o_out_second
);
    import dtpwm_pkg::*;

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         out1;
        logic         out2;
    } dtpwm_tmr_s;

    dtpwm_tmr_s s_reg;
    dtpwm_tmr_s s_next;
    logic [W-1:0] cnt_nx;

    // Counter clears on a match with the cycle value; outputs follow the compares.
    always_comb begin
        s_next = s_reg;
        cnt_nx = W'(CNT_CLEAR);
        o_wrap = i_run && (s_reg.cnt == i_period);
        if (i_run) begin
            cnt_nx = o_wrap ? W'(CNT_CLEAR) : W'(s_reg.cnt + 1'b1);
        end
        s_next.cnt  = cnt_nx;
        // High for cmp1-cmp0 counts; equal compares keep the default low level.
        s_next.out1 = i_run && (cnt_nx > i_cmp0) && (cnt_nx <= i_cmp1);
        s_next.out2 = i_run && i_dual && (cnt_nx > i_cmp2)
                      && (cnt_nx <= i_cmp3);
    end

    // State register, frozen while the clock enable is low.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            s_reg <= '0;
        end else if (i_ce) begin
            s_reg <= s_next;
        end
    end

    assign o_count      = s_reg.cnt;
    assign o_out_first  = s_reg.out1;
    assign o_out_second = s_reg.out2;

endmodule : dtpwm_timer

// file: dtpwm_top.sv
////////////////////////////////////////////////////////////////////////////////
//
// Decided for this implementation: the register offsets and register access over APB.
module dtpwm_top #(
    parameter int W = dtpwm_pkg::CNT_W
) (
    // Clock, reset and enable.
    input  wire logic                         i_clk,
    input  wire logic                         i_reset,
    input  wire logic                         i_ce,
    // APB slave.
    input  wire logic                         i_psel,
    input  wire logic                         i_penable,
    input  wire logic                         i_pwrite,
    input  wire logic [dtpwm_pkg::ADDR_W-1:0] i_paddr,
    input  wire logic [dtpwm_pkg::DATA_W-1:0] i_pwdata,
    output logic      [dtpwm_pkg::DATA_W-1:0] o_prdata,
    output logic                              o_pready,
    output logic                              o_pslverr,
    // PWM outputs and cycle match pulses.
    output logic                              o_primary_output_first,
    output logic                              o_primary_output_second,
    output logic                              o_secondary_output_first,
    output logic                              o_secondary_output_second,
    output logic                              o_primary_cycle_match_irq,
    output logic                              o_secondary_cycle_match_irq
);
    import dtpwm_pkg::*;

    typedef logic [NUM_TMR-1:0][NUM_CMP-1:0][W-1:0] dtpwm_cmp_t;

    typedef struct packed {
        logic [NUM_TMR-1:0]        run;
        logic [NUM_TMR-1:0]        dual;
        logic                      sync_run;
        dtpwm_mode_e               mode;
        dtpwm_cmp_t                buf_cmp;
        dtpwm_cmp_t                act_cmp;
        logic [NUM_TMR-1:0]        pend;
        logic [NUM_TMR-1:0][1:0]   age;
        logic                      pready;
        logic                      pslverr;
        logic [DATA_W-1:0]         prdata;
        logic [NUM_TMR-1:0]        irq;
        logic [3:0]                outs;
    } dtpwm_state_s;

    dtpwm_state_s s_reg;
    dtpwm_state_s s_next;

    ////////////////////////////////////////////////////////////////////////////
    // Timer instances and per-timer control.

    logic [NUM_TMR-1:0]        tmr_run;
    logic [NUM_TMR-1:0]        tmr_wrap;
    logic [NUM_TMR-1:0][W-1:0] tmr_period;
    logic [NUM_TMR-1:0][W-1:0] tmr_count;
    logic [NUM_TMR-1:0]        tmr_out1;
    logic [NUM_TMR-1:0]        tmr_out2;
    logic                      sync_mode;
    logic                      clear_mode;

    // Mode decode; a reserved mode code behaves as independent operation.
    assign sync_mode  = (s_reg.mode == DTPWM_MODE_SYNC_START)
                        || (s_reg.mode == DTPWM_MODE_SYNC_CLEAR);
    assign clear_mode = (s_reg.mode == DTPWM_MODE_SYNC_CLEAR);

    genvar g;
    generate
        for (g = 0; g < NUM_TMR; g++) begin : g_tmr
            // Run source and cycle length of each timer.
            assign tmr_run[g] = sync_mode ? s_reg.sync_run : s_reg.run[g];
            assign tmr_period[g] = clear_mode
                ? s_reg.act_cmp[0][dtpwm_commit_idx(s_reg.dual[0])]
                : s_reg.act_cmp[g][dtpwm_commit_idx(s_reg.dual[g])];

            dtpwm_timer #(
                .W (W)
            ) u_tmr (
                .i_clk        (i_clk),
                .i_reset      (i_reset),
                .i_ce         (i_ce),
                .i_run        (tmr_run[g]),
                .i_dual       (s_reg.dual[g]),
                .i_period     (tmr_period[g]),
                .i_cmp0       (s_reg.act_cmp[g][0]),
                .i_cmp1       (s_reg.act_cmp[g][1]),
                .i_cmp2       (s_reg.act_cmp[g][2]),
                .i_cmp3       (s_reg.act_cmp[g][3]),
                .o_count      (tmr_count[g]),
                .o_wrap       (tmr_wrap[g]),
                .o_out_first  (tmr_out1[g]),
                .o_out_second (tmr_out2[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode helpers.

    logic              acc;
    logic              wr_take;
    logic              cmp_hit;
    logic              tmr_sel;
    logic [1:0]        cmp_idx;
    logic              mapped;
    logic [NUM_TMR-1:0] commit_wr;

    // Phase of the APB transfer; a write lands on the edge that sees pready high.
    assign acc     = i_psel && i_penable;
    assign wr_take = acc && s_reg.pready && i_pwrite;
    assign cmp_idx = i_paddr[CMP_IDX_LSB +: 2];

    // Address decode of the compare windows and the control registers.
    always_comb begin
        cmp_hit = 1'b0;
        tmr_sel = 1'b0;
        mapped  = 1'b1;
        if ((i_paddr >= ADDR_CMP_T0) && (i_paddr < ADDR_CMP_T0 + CMP_SPAN)) begin
            cmp_hit = 1'b1;
        end else if ((i_paddr >= ADDR_CMP_T1) && (i_paddr < ADDR_CMP_T1 + CMP_SPAN)) begin
            cmp_hit = 1'b1;
            tmr_sel = 1'b1;
        end else if (i_paddr == ADDR_CTRL0_T0) begin
            mapped = 1'b1;
        end else if (i_paddr == ADDR_CTRL0_T1) begin
            mapped = 1'b1;
        end else if (i_paddr == ADDR_CTRL1_PRI) begin
            mapped = 1'b1;
        end else if (i_paddr == ADDR_STATUS) begin
            mapped = 1'b1;
        end else if (i_paddr == ADDR_COUNT) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
        if (i_paddr[1:0] != 2'h0) begin
            mapped = 1'b0;
        end
    end

    // A write to the closing compare of a timer commits its buffers; in clear mode only the primary's closing compare commits, for both timers.
    always_comb begin
        commit_wr = '0;
        if (wr_take && mapped && cmp_hit) begin
            if (clear_mode) begin
                commit_wr[0] = !tmr_sel
                               && (cmp_idx == dtpwm_commit_idx(s_reg.dual[0]));
            end else begin
                commit_wr[tmr_sel] = (cmp_idx == dtpwm_commit_idx(s_reg.dual[tmr_sel]));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state.

    logic [DATA_W-1:0] rd_val;
    logic              xfer;
    int                t;
    int                src;

    always_comb begin
        s_next = s_reg;
        rd_val = '0;
        xfer   = 1'b0;
        src    = 0;

        // Register writes into control fields and compare buffers.
        if (wr_take && mapped) begin
            if (cmp_hit) begin
                s_next.buf_cmp[tmr_sel][cmp_idx] = i_pwdata[W-1:0];
            end else if (i_paddr == ADDR_CTRL0_T0) begin
                s_next.run[0]  = i_pwdata[RUN_BIT];
                s_next.dual[0] = i_pwdata[DUAL_BIT];
            end else if (i_paddr == ADDR_CTRL0_T1) begin
                s_next.run[1]  = i_pwdata[RUN_BIT];
                s_next.dual[1] = i_pwdata[DUAL_BIT];
            end else if (i_paddr == ADDR_CTRL1_PRI) begin
                s_next.sync_run = i_pwdata[RUN_BIT];
                s_next.mode     = dtpwm_mode_e'(i_pwdata[MODE_LSB +: 2]);
            end
        end

        // Commit tracking and transfer of buffers into the active compares.
        for (t = 0; t < NUM_TMR; t++) begin
            src  = clear_mode ? 0 : t;
            // Commit write must precede the match cycle by at least two clocks.
            xfer = tmr_wrap[src] && s_reg.pend[src]
                   && (s_reg.age[src] >= AGE_COMMIT);
            if (!tmr_run[t]) begin
                // Stopped timers track the buffers so a start uses them at once.
                s_next.act_cmp[t] = s_reg.buf_cmp[t];
            end else if (xfer) begin
                s_next.act_cmp[t] = s_reg.buf_cmp[t];
            end
            if (xfer || !tmr_run[t]) begin
                s_next.pend[t] = 1'b0;
            end
            if (s_reg.age[t] != AGE_MAX) begin
                s_next.age[t] = s_reg.age[t] + 2'h1;
            end
            // A commit write wins over a transfer in the same cycle.
            if (commit_wr[t]) begin
                s_next.pend[t] = 1'b1;
                s_next.age[t]  = 2'h0;
            end
            s_next.irq[t] = tmr_wrap[t];
        end

        // Read data for the register being accessed.
        if (cmp_hit) begin
            rd_val[W-1:0] = s_reg.buf_cmp[tmr_sel][cmp_idx];
        end else if (i_paddr == ADDR_CTRL0_T0) begin
            rd_val[RUN_BIT]  = s_reg.run[0];
            rd_val[DUAL_BIT] = s_reg.dual[0];
        end else if (i_paddr == ADDR_CTRL0_T1) begin
            rd_val[RUN_BIT]  = s_reg.run[1];
            rd_val[DUAL_BIT] = s_reg.dual[1];
        end else if (i_paddr == ADDR_CTRL1_PRI) begin
            rd_val[RUN_BIT]          = s_reg.sync_run;
            rd_val[MODE_LSB +: 2]    = s_reg.mode;
        end else if (i_paddr == ADDR_STATUS) begin
            rd_val[ST_OUT_LSB +: 4]  = s_reg.outs;
            rd_val[ST_PEND_LSB +: 2] = s_reg.pend;
            rd_val[ST_RUN_LSB +: 2]  = tmr_run;
        end else if (i_paddr == ADDR_COUNT) begin
            rd_val = {tmr_count[1], tmr_count[0]};
        end

        // One wait state, then the answer with data or an error.
        s_next.pready  = acc && !s_reg.pready;
        s_next.pslverr = acc && !s_reg.pready && !mapped;
        s_next.prdata  = (acc && !s_reg.pready && !i_pwrite && mapped) ? rd_val : '0;

        // Pin levels collected for registered outputs.
        s_next.outs = {tmr_out2[1], tmr_out1[1], tmr_out2[0], tmr_out1[0]};
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register, frozen while the clock enable is low.

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            s_reg      <= '0;
            s_reg.mode <= DTPWM_MODE_INDEP;
        end else if (i_ce) begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, each straight from the state register.

    assign o_prdata                    = s_reg.prdata;
    assign o_pready                    = s_reg.pready;
    assign o_pslverr                   = s_reg.pslverr;
    assign o_primary_output_first      = s_reg.outs[0];
    assign o_primary_output_second     = s_reg.outs[1];
    assign o_secondary_output_first    = s_reg.outs[2];
    assign o_secondary_output_second   = s_reg.outs[3];
    assign o_primary_cycle_match_irq   = s_reg.irq[0];
    assign o_secondary_cycle_match_irq = s_reg.irq[1];

endmodule : dtpwm_top

// file: dtpwm_top_sva.sv
////////////////////////////////////////////////////////////////////////////////
// Watches the bus handshake, the match pulses and the state left by reset.
module dtpwm_top_sva #(
    parameter int W = dtpwm_pkg::CNT_W
) (
    // Clock, reset and enable.
    input wire logic        i_clk,
    input wire logic        i_reset,
    input wire logic        i_ce,
    // APB slave.
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [7:0]  i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    // PWM outputs and match pulses.
    input wire logic        o_primary_output_first,
    input wire logic        o_primary_output_second,
    input wire logic        o_secondary_output_first,
    input wire logic        o_secondary_output_second,
    input wire logic        o_primary_cycle_match_irq,
    input wire logic        o_secondary_cycle_match_irq
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    // An access phase still waiting, and an answer that stands one cycle.
    sequence acc_wait_s;
        i_psel && i_penable && !o_pready && i_ce;
    endsequence
    sequence answer_s;
        o_pready ##1 !o_pready;
    endsequence

    // Bus answers come after exactly one wait state and carry error only with ready.
    ready_answer_a: assert property (acc_wait_s |=> answer_s)
        else $error("access phase not answered after one wait state");
    ready_setup_a: assert property (i_psel && !i_penable |=> !o_pready)
        else $error("answer given in the first access cycle");
    err_ready_a: assert property (o_pslverr |-> o_pready)
        else $error("error flag without ready");
    rdata_idle_a: assert property (!o_pready |-> o_prdata == 32'h00000000)
        else $error("read data not zero outside the answer");
    bad_addr_a: assert property (i_psel && o_pready
        && (i_paddr[1:0] != 2'h0 || i_paddr > 8'h30) |-> o_pslverr)
        else $error("unmapped address answered without error");
    // Match pulses last a single cycle; a closing compare of zero gives a one-cycle period and a steady pulse.
    irq_pulse_a: assert property (o_primary_cycle_match_irq |=> !o_primary_cycle_match_irq)
        else $error("primary match pulse longer than one cycle");
    irq2_pulse_a: assert property (o_secondary_cycle_match_irq |=> !o_secondary_cycle_match_irq)
        else $error("secondary match pulse longer than one cycle");
    reset_quiet_a: assert property ($fell(i_reset) |-> !(o_primary_output_first
        || o_primary_output_second || o_secondary_output_first || o_secondary_output_second
        || o_primary_cycle_match_irq || o_secondary_cycle_match_irq || o_pready))
        else $error("pins not at default level after reset");
endmodule : dtpwm_top_sva

bind dtpwm_top dtpwm_top_sva #(.W(W)) u_sva (
    .i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_primary_output_first(o_primary_output_first),
    .o_primary_output_second(o_primary_output_second),
    .o_secondary_output_first(o_secondary_output_first),
    .o_secondary_output_second(o_secondary_output_second),
    .o_primary_cycle_match_irq(o_primary_cycle_match_irq),
    .o_secondary_cycle_match_irq(o_secondary_cycle_match_irq)
);

// file: dtpwm_top_tb_top.sv
// Compares a value with its expectation and counts the outcome.
`define CHK(got, want) \
    begin \
        comparisons++; \
        if ((got) !== (want)) begin \
            n_errors++; \
            $display("unexpected at %0t: got %0h want %0h", $time, got, want); \
        end \
    end

////////////////////////////////////////////////////////////////////////////////
// Self-checking bench: APB master, PWM load and one task per scenario.
module dtpwm_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dtpwm_pkg::*;

    // Bus, load and bookkeeping signals.
    logic        clk, rst, psel, pen, pwr, ld_clr, ld_en, rerr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, rdat;
    wire  [31:0] prdata;
    wire         pready, pslverr;
    wire  [5:0]  pins;
    logic [15:0] hi [6];
    int          n_errors, comparisons;

    // The clock enable stays high: every scenario counts on an unfrozen counter.
    dtpwm_top dut (
        .i_clk(clk), .i_reset(rst), .i_ce(1'b1), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_primary_output_first(pins[0]),
        .o_primary_output_second(pins[1]), .o_secondary_output_first(pins[2]),
        .o_secondary_output_second(pins[3]), .o_primary_cycle_match_irq(pins[4]),
        .o_secondary_cycle_match_irq(pins[5])
    );
    dtpwm_load u_load (.i_clk(clk), .i_clear(ld_clr), .i_en(ld_en), .i_pins(pins), .o_hi(hi));

    // Free-running 50 MHz clock.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic results;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    // A wait that ran out counts as a mismatch and closes the run.
    task automatic tmo(input int i, input int lim);
        if (i >= lim) begin
            n_errors++;
            $display("unexpected at %0t: wait ran out", $time);
            results();
        end
    endtask : tmo

    // One APB transfer, held until ready; an idle cycle follows the release.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        for (i = 0; pready !== 1'b1 && i < 50; i++) begin
            @(posedge clk);
        end
        tmo(i, 50);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
        @(posedge clk);
    endtask : xfer

    // Writes compare register i of timer t.
    task automatic wc(input int t, input int i, input logic [15:0] v);
        xfer(1'b1, ADDR_CMP_T0 + 8'(t) * CMP_SPAN + 8'(i * 4), {16'h0000, v});
    endtask : wc

    // Stops at the edge that closes a primary match pulse.
    task automatic wirq;
        int i;
        for (i = 0; pins[4] !== 1'b1 && i < 500; i++) begin
            @(posedge clk);
        end
        tmo(i, 500);
    endtask : wirq

    // Lets the load count n cycles, started after a primary match when w is set.
    task automatic meas(input int n, input logic w);
        ld_clr <= 1'b1;
        @(posedge clk);
        ld_clr <= 1'b0;
        if (w) begin
            wirq();
        end
        ld_en <= 1'b1;
        repeat (n) @(posedge clk);
        ld_en <= 1'b0;
        @(posedge clk);
    endtask : meas

    // Compares high counts of the four outputs and the primary pulse count.
    task automatic pwm(input int e [5]);
        for (int k = 0; k < 5; k++) begin
            `CHK(hi[k], e[k])
        end
    endtask : pwm

    ////////////////////////////////////////////////////////////////////////////
    // Reset values, upper compare bits, unmapped and misaligned addresses.
    task automatic t_regs;
        xfer(1'b0, ADDR_CMP_T1 + 8'h0c, 32'h00000000);
        `CHK(rdat, 32'h00000000)
        xfer(1'b1, ADDR_CMP_T1, 32'hffff1234);
        xfer(1'b0, ADDR_CMP_T1, 32'h00000000);
        `CHK(rdat, 32'h00001234)
        xfer(1'b0, 8'h34, 32'h00000000);
        `CHK(rerr, 1'b1)
        xfer(1'b1, 8'h11, 32'h00000005);
        `CHK(rerr, 1'b1)
    endtask : t_regs

    // Dual output on the primary timer: period 10, three periods counted.
    task automatic t_dual;
        wc(0, 0, 16'h0001);
        wc(0, 1, 16'h0004);
        wc(0, 2, 16'h0005);
        wc(0, 3, 16'h0009);
        xfer(1'b1, ADDR_CTRL0_T0, 32'h00000081);
        meas(30, 1'b1);
        pwm('{9, 12, 0, 0, 3});
    endtask : t_dual

    // Uncommitted writes wait; the latest values arrive with the commit.
    task automatic t_hold;
        wc(0, 0, 16'h0002);
        meas(10, 1'b1);
        pwm('{3, 4, 0, 0, 1});
        wc(0, 1, 16'h0006);
        wc(0, 1, 16'h0007);
        wc(0, 3, 16'h0009);
        meas(10, 1'b1);
        meas(10, 1'b1);
        pwm('{5, 4, 0, 0, 1});
    endtask : t_hold

    // Commit placed j edges after a match, at the edge of the deferral window.
    task automatic t_defer(input int j, input logic [15:0] c0, input int e0, input int e1);
        wc(0, 0, c0);
        wirq();
        repeat (j) @(posedge clk);
        wc(0, 3, 16'h0009);
        meas(10, 1'b1);
        pwm('{e0, 4, 0, 0, 1});
        meas(10, 1'b1);
        pwm('{e1, 4, 0, 0, 1});
    endtask : t_defer

    // Equal second pair holds the second output at its default level.
    task automatic t_eq;
        wc(0, 2, 16'h0009);
        wc(0, 3, 16'h0009);
        meas(10, 1'b1);
        meas(10, 1'b1);
        pwm('{0, 0, 0, 0, 1});
    endtask : t_eq

    // Synchronous start of both timers with their own settings, then stop.
    task automatic t_sync_start;
        xfer(1'b1, ADDR_CTRL0_T0, 32'h00000001);
        wc(0, 0, 16'h0001);
        wc(0, 2, 16'h0005);
        wc(1, 0, 16'h0001);
        wc(1, 1, 16'h0004);
        xfer(1'b1, ADDR_CTRL1_PRI, 32'h00000081);
        meas(10, 1'b1);
        pwm('{6, 4, 6, 0, 1});
        xfer(1'b1, ADDR_CTRL1_PRI, 32'h00000001);
        repeat (2) @(posedge clk);
        meas(20, 1'b0);
        pwm('{0, 0, 0, 0, 0});
    endtask : t_sync_start

    // Synchronous start and clear: the primary period governs every output.
    task automatic t_sync_clear;
        xfer(1'b1, ADDR_CTRL0_T0, 32'h00000000);
        xfer(1'b1, ADDR_CTRL0_T1, 32'h00000001);
        wc(0, 0, 16'h0002);
        wc(0, 1, 16'h0009);
        wc(1, 1, 16'h0003);
        wc(1, 2, 16'h0004);
        wc(1, 3, 16'h0007);
        xfer(1'b1, ADDR_CTRL1_PRI, 32'h00000083);
        meas(20, 1'b1);
        pwm('{14, 0, 4, 6, 2});
        `CHK(hi[5], 2)
        wc(1, 1, 16'h0005);
        wc(0, 1, 16'h0009);
        meas(10, 1'b1);
        meas(10, 1'b1);
        pwm('{7, 0, 4, 3, 1});
    endtask : t_sync_clear

    ////////////////////////////////////////////////////////////////////////////
    // Reset for twelve cycles, one idle edge, then every scenario in turn.
    initial begin
        rst         = 1'b1;
        psel        = 1'b0;
        pen         = 1'b0;
        pwr         = 1'b0;
        paddr       = 8'h00;
        pwdata      = 32'h00000000;
        ld_clr      = 1'b0;
        ld_en       = 1'b0;
        n_errors    = 0;
        comparisons = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_dual();
        t_hold();
        t_defer(3, 16'h0003, 4, 4);
        t_defer(4, 16'h0007, 4, 0);
        t_eq();
        t_sync_start();
        t_sync_clear();
        results();
    end
endmodule : dtpwm_top_tb_top
